// file: common/prog_entry_pkg.sv
// Constants shared by the serial programming entry block.
// Assumes a 250 MHz system clock and a register port with one-cycle read latency.
package prog_entry_pkg;
    localparam int KEY_BITS = 32;
    localparam int SYNC_STAGES = 2;
    localparam logic [31:0] ENTRY_KEY_DEFAULT = 32'h5a3c_96e1; // Arbitrary key value.
    localparam logic [7:0] OFS_LOCK_KEY = 8'h38;
    localparam logic [7:0] OFS_PORT_ENABLE = 8'h39;
    localparam logic [7:0] OFS_CONFIG = 8'h3a;
    localparam logic [7:0] OFS_STATUS = 8'h3b;
    localparam logic [7:0] OFS_RX_DATA = 8'h3c;
    localparam logic [7:0] OFS_TX_DATA = 8'h3d;
    localparam logic [7:0] LOCK_KEY_RESET = 8'h00;
    localparam logic [7:0] PORT_ENABLE_RESET = 8'h01;
    localparam logic [7:0] LOCK_KEY_UNLOCK = 8'ha5;
    localparam int BIT_PORT_EN = 0;
    localparam int BIT_LV_ENABLE = 0;
    localparam int BIT_ST_ACTIVE = 0;
    localparam int BIT_ST_HV = 1;
    localparam int BIT_ST_LV = 2;
    localparam int BIT_ST_RESET = 3;
    localparam int BIT_ST_KEYFAIL = 4;
    localparam int BIT_ST_LV_ENABLE = 5;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HOLD = 3'b001,
        ST_HV = 3'b010,
        ST_LV = 3'b011,
        ST_FAIL = 3'b100
    } entry_state_t;
endpackage

// file: core/prog_entry.sv
// Entry controller for the two-wire serial programming port.
// Assumes programmer pins are asynchronous and the link clock comes from the programmer.
`timescale 1ns/10ps
// Overview of operation
// - Clock and data low, then master clear at high level, enters high-voltage mode.
// - Low-voltage entry accepted only while the low-voltage enable bit is one.
// - With master clear low, a 32-bit key is shifted in and compared.
// - Low-voltage Program/Verify mode persists only while master clear stays low; high-voltage mode ends when the high level drops.
// - Low-voltage enable forces the master-clear reset function on.
// - Clearing the low-voltage enable bit allowed only in a high-voltage session.
// - Clock pin is an input clock; data pin is bidirectional.
// - Program/Verify mode allows serial writing and verifying of memory and configuration.
module prog_entry
    import prog_entry_pkg::*;
#(
    parameter logic [31:0] ENTRY_KEY = ENTRY_KEY_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic prog_clock_pin,
    input wire logic prog_data_pin_in,
    output logic prog_data_pin_out,
    output logic prog_data_pin_oe_n,
    input wire logic master_clear_pin_n,
    input wire logic master_clear_high_voltage,
    input wire logic master_clear_function_cfg,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic program_verify_mode,
    output logic device_reset_hold,
    output logic master_clear_reset_enable
);
    // ****************************************
    // Link domain: key and data shift on programmer clock.
    // ****************************************
    logic [KEY_BITS-1:0] lk_shift_reg;
    logic [KEY_BITS-1:0] lk_shift_next;
    logic [5:0] lk_count_reg;
    logic [5:0] lk_count_next;
    logic lk_full_reg;
    logic lk_full_next;
    logic [7:0] lk_tx_reg;
    logic [7:0] lk_tx_next;
    logic [1:0] lk_master_clear_sync_reg;
    logic [1:0] lk_tx_load_sync_reg;
    logic lk_tx_load_seen_reg;
    logic lk_tx_load_seen_next;
    logic tx_load_tgl_reg;
    logic [7:0] tx_hold_reg;

    always_comb begin
        lk_shift_next = {lk_shift_reg[KEY_BITS-2:0], prog_data_pin_in};
        lk_count_next = lk_count_reg;
        lk_full_next = lk_full_reg;
        lk_tx_next = {lk_tx_reg[6:0], 1'b0};
        lk_tx_load_seen_next = lk_tx_load_sync_reg[1];
        if (lk_tx_load_sync_reg[1] != lk_tx_load_seen_reg) begin
            lk_tx_next = tx_hold_reg;
        end
        if (lk_master_clear_sync_reg[1]) begin
            lk_count_next = 6'h00;
            lk_full_next = 1'b0;
        end else if (lk_count_reg == 6'(KEY_BITS - 1)) begin
            lk_full_next = 1'b1;
            lk_count_next = lk_count_reg + 6'h01;
        end else if (!lk_full_reg) begin
            lk_count_next = lk_count_reg + 6'h01;
        end
    end

    always_ff @(posedge prog_clock_pin) begin
        lk_master_clear_sync_reg <= {lk_master_clear_sync_reg[0], master_clear_pin_n};
        lk_tx_load_sync_reg <= {lk_tx_load_sync_reg[0], tx_load_tgl_reg};
        lk_shift_reg <= lk_shift_next;
        lk_count_reg <= lk_count_next;
        lk_full_reg <= lk_full_next;
        lk_tx_reg <= lk_tx_next;
        lk_tx_load_seen_reg <= lk_tx_load_seen_next;
    end

    // Data is driven back on the falling edge while in a session.
    always_ff @(negedge prog_clock_pin) begin
        prog_data_pin_out <= lk_tx_reg[7];
    end

    // ****************************************
    // System domain synchronisers.
    // ****************************************
    logic [SYNC_STAGES-1:0] master_clear_sync_reg;
    logic [SYNC_STAGES-1:0] hv_sync_reg;
    logic [SYNC_STAGES-1:0] clk_pin_sync_reg;
    logic [SYNC_STAGES-1:0] dat_pin_sync_reg;
    logic [SYNC_STAGES-1:0] full_sync_reg;
    logic full_seen_reg;
    logic master_clear_low;
    logic hv_high;
    logic clk_low;
    logic dat_low;
    logic key_done;

    always_ff @(posedge clk) begin
        master_clear_sync_reg <= {master_clear_sync_reg[0], master_clear_pin_n};
        hv_sync_reg <= {hv_sync_reg[0], master_clear_high_voltage};
        clk_pin_sync_reg <= {clk_pin_sync_reg[0], prog_clock_pin};
        dat_pin_sync_reg <= {dat_pin_sync_reg[0], prog_data_pin_in};
        full_sync_reg <= {full_sync_reg[0], lk_full_reg};
        full_seen_reg <= full_sync_reg[1];
    end

    assign master_clear_low = !master_clear_sync_reg[1];
    assign hv_high = hv_sync_reg[1];
    assign clk_low = !clk_pin_sync_reg[1];
    assign dat_low = !dat_pin_sync_reg[1];
    assign key_done = full_sync_reg[1] && !full_seen_reg;

    // Key is stable once the full flag has crossed, so it is sampled as a word.
    logic [KEY_BITS-1:0] key_snap_reg;
    always_ff @(posedge clk) begin
        if (key_done) begin
            key_snap_reg <= lk_shift_reg;
        end
    end

    // ****************************************
    // Registers and entry state machine.
    // ****************************************
    entry_state_t state_reg;
    entry_state_t state_next;
    logic [7:0] lock_key_reg;
    logic [7:0] lock_key_next;
    logic [7:0] port_enable_reg;
    logic [7:0] port_enable_next;
    logic low_voltage_prog_enable_reg;
    logic low_voltage_prog_enable_next;
    logic key_fail_reg;
    logic key_fail_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] tx_hold_next;
    logic tx_load_tgl_next;
    logic key_check_reg;
    logic key_check_next;
    logic port_on;
    logic in_session;

    assign port_on = port_enable_reg[BIT_PORT_EN];
    assign in_session = (state_reg == ST_HV) || (state_reg == ST_LV);

    always_comb begin
        state_next = state_reg;
        lock_key_next = lock_key_reg;
        port_enable_next = port_enable_reg;
        low_voltage_prog_enable_next = low_voltage_prog_enable_reg;
        key_fail_next = key_fail_reg;
        tx_hold_next = tx_hold_reg;
        tx_load_tgl_next = tx_load_tgl_reg;
        key_check_next = key_done;
        rdata_next = 8'h00;
        case (state_reg)
            ST_RUN: begin
                if (hv_high && clk_low && dat_low && port_on) begin
                    state_next = ST_HV;
                end else if (master_clear_low) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hv_high && clk_low && dat_low && port_on) begin
                    state_next = ST_HV;
                end else if (!master_clear_low) begin
                    state_next = ST_RUN;
                end else if (key_check_reg && low_voltage_prog_enable_reg && port_on) begin
                    if (key_snap_reg == ENTRY_KEY) begin
                        state_next = ST_LV;
                    end else begin
                        state_next = ST_FAIL;
                        key_fail_next = 1'b1;
                    end
                end
            end
            ST_HV: begin
                if (!hv_high) begin
                    state_next = master_clear_low ? ST_HOLD : ST_RUN;
                end
            end
            ST_LV: begin
                if (!master_clear_low) begin
                    state_next = ST_RUN;
                end
            end
            ST_FAIL: begin
                if (!master_clear_low) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (reg_write) begin
            if (reg_addr == OFS_LOCK_KEY) begin
                lock_key_next = reg_wdata;
            end else if (reg_addr == OFS_PORT_ENABLE && lock_key_reg == LOCK_KEY_UNLOCK) begin
                port_enable_next = reg_wdata & 8'h01;
            end else if (reg_addr == OFS_CONFIG && in_session) begin
                if (reg_wdata[BIT_LV_ENABLE] || state_reg == ST_HV) begin
                    low_voltage_prog_enable_next = reg_wdata[BIT_LV_ENABLE];
                end
            end else if (reg_addr == OFS_TX_DATA && in_session) begin
                tx_hold_next = reg_wdata;
                tx_load_tgl_next = !tx_load_tgl_reg;
            end
        end
        if (reg_read) begin
            if (reg_addr == OFS_LOCK_KEY) begin
                rdata_next = lock_key_reg;
            end else if (reg_addr == OFS_PORT_ENABLE) begin
                rdata_next = port_enable_reg;
            end else if (reg_addr == OFS_CONFIG) begin
                rdata_next = {7'h00, low_voltage_prog_enable_reg};
            end else if (reg_addr == OFS_STATUS) begin
                rdata_next = {2'h0, low_voltage_prog_enable_reg, key_fail_reg,
                              device_reset_hold,
                              state_reg == ST_LV, state_reg == ST_HV, in_session};
            end else if (reg_addr == OFS_RX_DATA) begin
                rdata_next = key_snap_reg[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            lock_key_reg <= LOCK_KEY_RESET;
            port_enable_reg <= PORT_ENABLE_RESET;
            low_voltage_prog_enable_reg <= 1'b1;
            key_fail_reg <= 1'b0;
            rdata_reg <= 8'h00;
            tx_hold_reg <= 8'h00;
            tx_load_tgl_reg <= 1'b0;
            key_check_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lock_key_reg <= lock_key_next;
            port_enable_reg <= port_enable_next;
            low_voltage_prog_enable_reg <= low_voltage_prog_enable_next;
            key_fail_reg <= key_fail_next;
            rdata_reg <= rdata_next;
            tx_hold_reg <= tx_hold_next;
            tx_load_tgl_reg <= tx_load_tgl_next;
            key_check_reg <= key_check_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign program_verify_mode = in_session;
    assign master_clear_reset_enable = low_voltage_prog_enable_reg
        || master_clear_function_cfg;
    assign device_reset_hold = (state_reg != ST_RUN);
    assign prog_data_pin_oe_n = !in_session;

    // ****************************************
    // Assertions.
    // ****************************************
    hv_entry_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg inside {ST_RUN, ST_HOLD} && hv_high && clk_low && dat_low && port_on)
        |=> state_reg == ST_HV)
        else $error("High-voltage entry not taken.");
    lv_gate_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_HOLD && $changed(state_reg) == 0 && !low_voltage_prog_enable_reg)
        |=> state_reg != ST_LV)
        else $error("Low-voltage entry with enable clear.");
    key_match_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_HOLD && state_next == ST_LV) |-> key_snap_reg == ENTRY_KEY)
        else $error("Entry without matching key.");
    lv_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_LV && !master_clear_low) |=> !program_verify_mode)
        else $error("Session kept after master clear release.");
    reset_force_a: assert property (@(posedge clk) disable iff (rst)
        low_voltage_prog_enable_reg |-> master_clear_reset_enable)
        else $error("Master clear function off with enable set.");
    lv_enable_clear_a: assert property (@(posedge clk) disable iff (rst)
        ($past(low_voltage_prog_enable_reg) && !low_voltage_prog_enable_reg)
        |-> $past(state_reg) == ST_HV)
        else $error("Enable cleared outside high-voltage session.");
    data_dir_a: assert property (@(posedge clk) disable iff (rst)
        prog_data_pin_oe_n == !program_verify_mode)
        else $error("Data pin driven outside session.");
    key_fail_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_FAIL && master_clear_low)
        |=> (state_reg == ST_FAIL && device_reset_hold))
        else $error("Left reset hold after bad key.");
endmodule

// file: tb/prog_programmer_model.sv
// Behavioural model of the external programmer that drives the serial programming pins.
// Assumes the bench resolves the data pin level from both drivers.
`timescale 1ns/10ps
module prog_programmer_model
    import prog_entry_pkg::*;
(
    output logic prog_clock_pin,
    output logic data_drive,
    output logic master_clear_pin_n,
    output logic master_clear_high_voltage
);
    initial begin
        prog_clock_pin = 1'b0;
        data_drive = 1'b0;
        master_clear_pin_n = 1'b1;
        master_clear_high_voltage = 1'b0;
    end

    // One link clock period of 125 ns; the clock stands low between frames.
    task automatic clk_pulse();
        #62.5 prog_clock_pin = 1'b1;
        #62.5 prog_clock_pin = 1'b0;
    endtask

    // Clears the link counter, lowers master clear, pads the sync stages, then shifts the key.
    task automatic send_key(input logic [31:0] key);
        repeat (4) clk_pulse();
        master_clear_pin_n = 1'b0;
        #500;
        repeat (SYNC_STAGES) clk_pulse();
        for (int i = 31; i >= 0; i--) begin
            data_drive = key[i];
            clk_pulse();
        end
        data_drive = ~data_drive;
    endtask

    // Clock and data held low before master clear reaches the programming level.
    task automatic hv_enter();
        data_drive = 1'b0;
        prog_clock_pin = 1'b0;
        master_clear_pin_n = 1'b1;
        #100;
        master_clear_high_voltage = 1'b1;
    endtask

    // Master clear returns high, which ends any session.
    task automatic end_session();
        master_clear_high_voltage = 1'b0;
        master_clear_pin_n = 1'b1;
        data_drive = ~data_drive;
    endtask
endmodule

// file: tb/tb_serial_programming_entry.sv
// Self-checking bench for the serial programming entry block.
// Assumes the programmer model drives the pins and the register port speaks one-cycle reads.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module tb_serial_programming_entry
    import prog_entry_pkg::*;
;
    logic clk, rst, prog_clock_pin, data_drive, data_level;
    logic master_clear_pin_n, master_clear_high_voltage, master_clear_function_cfg;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, reg_read, prog_data_pin_out, prog_data_pin_oe_n;
    logic program_verify_mode, device_reset_hold, master_clear_reset_enable;
    int fails = 0;
    int check_count = 0;
    localparam logic [7:0] TX_PATTERN = 8'h96;

    assign data_level = prog_data_pin_oe_n ? data_drive : prog_data_pin_out;

    prog_programmer_model u_prog_programmer_model (.prog_clock_pin(prog_clock_pin),
        .data_drive(data_drive), .master_clear_pin_n(master_clear_pin_n),
        .master_clear_high_voltage(master_clear_high_voltage));

    prog_entry u_prog_entry (.clk(clk), .rst(rst), .prog_clock_pin(prog_clock_pin),
        .prog_data_pin_in(data_level), .prog_data_pin_out(prog_data_pin_out),
        .prog_data_pin_oe_n(prog_data_pin_oe_n), .master_clear_pin_n(master_clear_pin_n),
        .master_clear_high_voltage(master_clear_high_voltage),
        .master_clear_function_cfg(master_clear_function_cfg), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .program_verify_mode(program_verify_mode), .device_reset_hold(device_reset_hold),
        .master_clear_reset_enable(master_clear_reset_enable));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic wait_pvm(input logic e);
        for (int i = 0; i < 400 && program_verify_mode !== e; i++) @(posedge clk);
        `CHK(program_verify_mode, e)
        if (program_verify_mode !== e) begin
            end_of_test();
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        master_clear_function_cfg = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_LOCK_KEY, 8'h00);
        rd(OFS_PORT_ENABLE, 8'h01);
        rd(OFS_CONFIG, 8'h01);
        rd(OFS_STATUS, 8'h20);
        rd(8'h00, 8'h00);
        `CHK(master_clear_reset_enable, 1'b1)
        wr(OFS_PORT_ENABLE, 8'h00);
        rd(OFS_PORT_ENABLE, 8'h01);
        wr(OFS_LOCK_KEY, LOCK_KEY_UNLOCK);
        wr(OFS_PORT_ENABLE, 8'h00);
        rd(OFS_PORT_ENABLE, 8'h00);
        wr(OFS_PORT_ENABLE, 8'h01);
        rd(OFS_PORT_ENABLE, 8'h01);
        wr(OFS_LOCK_KEY, 8'h00);
        // Low-voltage entry with the right key, then an attempt to clear the enable bit.
        u_prog_programmer_model.send_key(ENTRY_KEY_DEFAULT);
        wait_pvm(1'b1);
        `CHK(prog_data_pin_oe_n, 1'b0)
        rd(OFS_STATUS, 8'h2d);
        rd(OFS_RX_DATA, ENTRY_KEY_DEFAULT[7:0]);
        wr(OFS_CONFIG, 8'h00);
        rd(OFS_CONFIG, 8'h01);
        // A byte written for read-back leaves on the data pin, most significant bit first.
        wr(OFS_TX_DATA, TX_PATTERN);
        repeat (3) u_prog_programmer_model.clk_pulse();
        for (int i = 7; i >= 0; i--) begin
            #10;
            `CHK(prog_data_pin_out, TX_PATTERN[i])
            u_prog_programmer_model.clk_pulse();
        end
        u_prog_programmer_model.end_session();
        wait_pvm(1'b0);
        repeat (10) @(posedge clk);
        `CHK(device_reset_hold, 1'b0)
        // Wrong key keeps the device held in reset.
        u_prog_programmer_model.send_key(~ENTRY_KEY_DEFAULT);
        repeat (100) @(posedge clk);
        `CHK(program_verify_mode, 1'b0)
        `CHK(device_reset_hold, 1'b1)
        rd(OFS_STATUS, 8'h38);
        u_prog_programmer_model.end_session();
        repeat (20) @(posedge clk);
        `CHK(device_reset_hold, 1'b0)
        // High-voltage session may clear the enable bit.
        u_prog_programmer_model.hv_enter();
        wait_pvm(1'b1);
        wr(OFS_CONFIG, 8'h00);
        rd(OFS_CONFIG, 8'h00);
        rd(OFS_STATUS, 8'h1b);
        `CHK(master_clear_reset_enable, 1'b0)
        u_prog_programmer_model.end_session();
        wait_pvm(1'b0);
        // Correct key is refused with the enable bit cleared.
        u_prog_programmer_model.send_key(ENTRY_KEY_DEFAULT);
        repeat (100) @(posedge clk);
        `CHK(program_verify_mode, 1'b0)
        u_prog_programmer_model.end_session();
        master_clear_function_cfg <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(master_clear_reset_enable, 1'b1)
        end_of_test();
    end
endmodule
